//--- hw/l1_debug_defines.svh
/*
 * Constants for the level-one array debug access block: coprocessor selector
 * codes, entry field widths and staging register reset value.
 * Assumes the includer already sits behind the system control coprocessor decode.
 */
`ifndef L1_DEBUG_DEFINES_SVH
`define L1_DEBUG_DEFINES_SVH

// selector (crm) codes
`define SEL_DATA_WR 4'h0
`define SEL_INSTR_WR 4'h1
`define SEL_DATA_RD 4'h2
`define SEL_INSTR_RD 4'h3
`define SEL_BRANCH_WR 4'h5
`define SEL_BRANCH_RD 4'h7

// second opcode codes
`define OP2_STAGE_LOW 3'h0
`define OP2_STAGE_HIGH 3'h1
`define OP2_CAM 3'h2
`define OP2_ATTR 3'h3
`define OP2_PA 3'h4
`define OP2_HASH 3'h5
`define OP2_TAG 3'h6
`define OP2_DATA 3'h7
`define OP2_GHB 3'h2
`define OP2_BTB 3'h3

// entry field widths
`define CAM_HI_W 5
`define ATTR_W 12
`define PA_W 29
`define HASH_W 8
`define TAG_W 23
`define DATA_HI_W 6
`define BTB_HI_W 28

`define STAGE_RESET 32'h0000_0000

`endif

//--- hw/l1_debug_pkg.sv
/*
 * Types for the level-one array debug access block.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package l1_debug_pkg;

    typedef enum logic [3:0] {
        KIND_NONE,
        KIND_CAM,
        KIND_ATTR,
        KIND_PA,
        KIND_HASH,
        KIND_TAG,
        KIND_DATA,
        KIND_BTB,
        KIND_GHB
    } array_kind_type;

endpackage : l1_debug_pkg

//--- hw/l1_array_debug_access.sv
/*
 * Debug access path to the level-one arrays: two staging register pairs and
 * the array read/write operations issued through coprocessor instructions.
 * Assumes the core hands over one decoded c15/opc1=0 access per cycle, with
 * mode bits on the same clock; the answer appears on the following cycle.
 */
`timescale 1ns/1ps
`include "l1_debug_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module l1_array_debug_access #(
    parameter int IDX_W = 4
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // coprocessor request
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [3:0] req_crm_in,
    input wire logic [2:0] req_opc2_in,
    input wire logic [31:0] req_data_in,
    // current processor mode
    input wire logic mode_secure_in,
    input wire logic mode_priv_in,
    // answer
    output logic resp_valid_out,
    output logic resp_undef_out,
    output logic [31:0] resp_data_out
);

    localparam int DEPTH = 1 << IDX_W;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic l1_debug_pkg::array_kind_type decode_kind(
        input logic [3:0] crm,
        input logic [2:0] opc2
    );
        decode_kind = l1_debug_pkg::KIND_NONE;
        if (crm[3:2] == 2'b00) begin
            unique case (opc2)
                `OP2_CAM: decode_kind = l1_debug_pkg::KIND_CAM;
                `OP2_ATTR: decode_kind = l1_debug_pkg::KIND_ATTR;
                `OP2_PA: decode_kind = l1_debug_pkg::KIND_PA;
                `OP2_HASH: decode_kind = l1_debug_pkg::KIND_HASH;
                `OP2_TAG: decode_kind = l1_debug_pkg::KIND_TAG;
                `OP2_DATA: decode_kind = l1_debug_pkg::KIND_DATA;
                default: decode_kind = l1_debug_pkg::KIND_NONE;
            endcase
        end else if (crm == `SEL_BRANCH_WR || crm == `SEL_BRANCH_RD) begin
            if (opc2 == `OP2_BTB) begin
                decode_kind = l1_debug_pkg::KIND_BTB;
            end else if (opc2 == `OP2_GHB) begin
                decode_kind = l1_debug_pkg::KIND_GHB;
            end
        end
    endfunction : decode_kind

    l1_debug_pkg::array_kind_type kind;
    logic allowed;
    logic is_stage;
    logic stage_side;
    logic stage_high;
    logic arr_legal;
    logic arr_side;
    logic arr_is_read;
    logic accept;
    logic refused;
    logic stage_wr;
    logic stage_rd;
    logic arr_wr;
    logic arr_rd;
    logic wide_kind;
    logic [IDX_W:0] idx;

    assign kind = decode_kind(req_crm_in, req_opc2_in);
    assign allowed = mode_secure_in & mode_priv_in;
    assign is_stage = (req_crm_in[3:1] == 3'b000) && (req_opc2_in[2:1] == 2'b00);
    assign stage_side = req_crm_in[0];
    assign stage_high = req_opc2_in[0];
    // array operations are write-instruction only; the read form is illegal
    assign arr_legal = req_write_in && (kind != l1_debug_pkg::KIND_NONE);
    // branch predictor arrays sit on the instruction side only
    assign arr_side = req_crm_in[2] | req_crm_in[0];
    assign arr_is_read = req_crm_in[1];
    assign accept = req_valid_in && allowed && (is_stage || arr_legal);
    assign refused = req_valid_in && !accept;
    assign stage_wr = accept && is_stage && req_write_in;
    assign stage_rd = accept && is_stage && !req_write_in;
    assign arr_wr = accept && !is_stage && !arr_is_read;
    assign arr_rd = accept && !is_stage && arr_is_read;
    // only entries wider than a word touch the high staging register
    assign wide_kind = (kind == l1_debug_pkg::KIND_CAM) || (kind == l1_debug_pkg::KIND_DATA)
        || (kind == l1_debug_pkg::KIND_BTB);
    // entry selector layout is taken as its low bits; side picks the bank
    assign idx = {arr_side, req_data_in[IDX_W-1:0]};

    ////////////////////////////////////////////////////////////////////////////
    // arrays

    logic [`CAM_HI_W+31:0] cam_mem [0:2*DEPTH-1];
    logic [`ATTR_W-1:0] attr_mem [0:2*DEPTH-1];
    logic [`PA_W-1:0] pa_mem [0:2*DEPTH-1];
    logic [`HASH_W-1:0] hash_mem [0:2*DEPTH-1];
    logic [`TAG_W-1:0] tag_mem [0:2*DEPTH-1];
    logic [`DATA_HI_W+31:0] data_mem [0:2*DEPTH-1];
    logic [`BTB_HI_W+31:0] btb_mem [0:DEPTH-1];
    logic [31:0] ghb_mem [0:DEPTH-1];

    logic [31:0] stage_lo_q [2];
    logic [31:0] stage_hi_q [2];
    logic [31:0] wr_lo;
    logic [31:0] wr_hi;
    logic [31:0] rd_lo;
    logic [31:0] rd_hi;

    assign wr_lo = stage_lo_q[arr_side];
    assign wr_hi = stage_hi_q[arr_side];

    // arrays hold no reset; their content is whatever was last written
    always_ff @(posedge core_clk_in) begin
        if (arr_wr) begin
            unique case (kind)
                l1_debug_pkg::KIND_CAM: cam_mem[idx] <= {wr_hi[`CAM_HI_W-1:0], wr_lo};
                l1_debug_pkg::KIND_ATTR: attr_mem[idx] <= wr_lo[`ATTR_W-1:0];
                l1_debug_pkg::KIND_PA: pa_mem[idx] <= wr_lo[`PA_W-1:0];
                l1_debug_pkg::KIND_HASH: hash_mem[idx] <= wr_lo[`HASH_W-1:0];
                l1_debug_pkg::KIND_TAG: tag_mem[idx] <= wr_lo[`TAG_W-1:0];
                l1_debug_pkg::KIND_DATA:
                    data_mem[idx] <= {wr_hi[`DATA_HI_W-1:0], wr_lo};
                l1_debug_pkg::KIND_BTB:
                    btb_mem[idx[IDX_W-1:0]] <= {wr_hi[`BTB_HI_W-1:0], wr_lo};
                l1_debug_pkg::KIND_GHB: ghb_mem[idx[IDX_W-1:0]] <= wr_lo;
                default: ;
            endcase
        end
    end

    // reserved bits come back as zero
    always_comb begin
        rd_lo = 32'h0000_0000;
        rd_hi = 32'h0000_0000;
        unique case (kind)
            l1_debug_pkg::KIND_CAM: begin
                rd_lo = cam_mem[idx][31:0];
                rd_hi = 32'(cam_mem[idx][`CAM_HI_W+31:32]);
            end
            l1_debug_pkg::KIND_ATTR: rd_lo = 32'(attr_mem[idx]);
            l1_debug_pkg::KIND_PA: rd_lo = 32'(pa_mem[idx]);
            l1_debug_pkg::KIND_HASH: rd_lo = 32'(hash_mem[idx]);
            l1_debug_pkg::KIND_TAG: rd_lo = 32'(tag_mem[idx]);
            l1_debug_pkg::KIND_DATA: begin
                rd_lo = data_mem[idx][31:0];
                rd_hi = 32'(data_mem[idx][`DATA_HI_W+31:32]);
            end
            l1_debug_pkg::KIND_BTB: begin
                rd_lo = btb_mem[idx[IDX_W-1:0]][31:0];
                rd_hi = 32'(btb_mem[idx[IDX_W-1:0]][`BTB_HI_W+31:32]);
            end
            l1_debug_pkg::KIND_GHB: rd_lo = ghb_mem[idx[IDX_W-1:0]];
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // staging registers

    logic [31:0] stage_lo_d [2];
    logic [31:0] stage_hi_d [2];

    always_comb begin
        for (int s = 0; s < 2; s++) begin
            stage_lo_d[s] = stage_lo_q[s];
            stage_hi_d[s] = stage_hi_q[s];
            if (stage_wr && stage_side == 1'(s)) begin
                if (stage_high) begin
                    stage_hi_d[s] = req_data_in;
                end else begin
                    stage_lo_d[s] = req_data_in;
                end
            end
            if (arr_rd && arr_side == 1'(s)) begin
                stage_lo_d[s] = rd_lo;
                if (wide_kind) begin
                    stage_hi_d[s] = rd_hi;
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage_lo_q <= '{`STAGE_RESET, `STAGE_RESET};
            stage_hi_q <= '{`STAGE_RESET, `STAGE_RESET};
        end else begin
            stage_lo_q <= stage_lo_d;
            stage_hi_q <= stage_hi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer

    logic [31:0] stage_rd_val;
    logic resp_valid_q;
    logic resp_undef_q;
    logic [31:0] resp_data_q;

    assign stage_rd_val = stage_high ? stage_hi_q[stage_side] : stage_lo_q[stage_side];

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            resp_valid_q <= 1'b0;
            resp_undef_q <= 1'b0;
            resp_data_q <= 32'h0000_0000;
        end else begin
            resp_valid_q <= req_valid_in;
            resp_undef_q <= refused;
            resp_data_q <= stage_rd ? stage_rd_val : 32'h0000_0000;
        end
    end

    assign resp_valid_out = resp_valid_q;
    assign resp_undef_out = resp_undef_q;
    assign resp_data_out = resp_data_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic chk_rd_q;
    logic chk_side_q;
    logic [31:0] chk_lo_q;
    l1_debug_pkg::array_kind_type chk_kind_q;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            chk_rd_q <= 1'b0;
            chk_side_q <= 1'b0;
            chk_lo_q <= 32'h0000_0000;
            chk_kind_q <= l1_debug_pkg::KIND_NONE;
        end else begin
            chk_rd_q <= arr_rd;
            chk_side_q <= arr_side;
            chk_lo_q <= rd_lo;
            chk_kind_q <= kind;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    refuse_mode_a:
        assert property (req_valid_in && !allowed |=> resp_valid_out && resp_undef_out)
        else $error("access outside secure privileged mode not refused");
    refuse_stable_a:
        assert property (refused |=> $stable(stage_lo_q[0]) && $stable(stage_hi_q[0])
            && $stable(stage_lo_q[1]) && $stable(stage_hi_q[1]))
        else $error("refused access changed a staging register");
    stage_loop_a:
        assert property (stage_wr && !stage_high |=> stage_lo_q[$past(stage_side)]
            == $past(req_data_in))
        else $error("staging low write not stored");
    read_fill_a:
        assert property (chk_rd_q |-> stage_lo_q[chk_side_q] == chk_lo_q)
        else $error("array read did not reach staging low");
    attr_reserved_a:
        assert property (arr_rd && kind == l1_debug_pkg::KIND_ATTR
            |=> stage_lo_q[chk_side_q][31:12] == 20'h00000)
        else $error("attribute reserved bits not zero");
    pa_reserved_a:
        assert property (arr_rd && kind == l1_debug_pkg::KIND_PA
            |=> stage_lo_q[chk_side_q][31:29] == 3'h0)
        else $error("physical-address reserved bits not zero");
    cam_high_a:
        assert property (arr_rd && kind == l1_debug_pkg::KIND_CAM
            |=> stage_hi_q[chk_side_q][31:5] == 27'h0000000)
        else $error("content-match high reserved bits not zero");
    narrow_high_a:
        assert property (arr_rd && !wide_kind && !stage_wr
            |=> $stable(stage_hi_q[0]) && $stable(stage_hi_q[1]))
        else $error("narrow entry read touched a high register");
    branch_side_a:
        assert property (arr_rd && (kind == l1_debug_pkg::KIND_BTB
            || kind == l1_debug_pkg::KIND_GHB) && !stage_wr |=> $stable(stage_lo_q[0]))
        else $error("branch predictor read touched data side");
    stage_read_a:
        assert property (stage_rd ##1 1'b1 |-> resp_data_out == $past(stage_rd_val)
            && !resp_undef_out)
        else $error("staging read answered wrongly");

    cover_arr_write_c: cover property (arr_wr ##1 arr_rd);
    cover_refused_c: cover property (refused);
    cover_btb_read_c: cover property (arr_rd && kind == l1_debug_pkg::KIND_BTB);
    cover_data_rd_c: cover property (chk_rd_q && chk_kind_q == l1_debug_pkg::KIND_DATA);

endmodule : l1_array_debug_access

//--- bench/l1_array_debug_access_bench.sv
/*
 * Self-checking bench for the level-one array debug access block: staging
 * registers, array write/read round trips for every array kind and side, refusals.
 * Assumes the defines header is on the include path and one answer per request.
 */
`timescale 1ns/1ps
`include "l1_debug_defines.svh"

module l1_array_debug_access_bench;
    logic core_clk_in, arst_n_in, req_valid_in, req_write_in, mode_secure_in, mode_priv_in;
    logic [3:0] req_crm_in;
    logic [2:0] req_opc2_in;
    logic [31:0] req_data_in, resp_data_out, rd;
    logic resp_valid_out, resp_undef_out;
    int num_errors = 0;
    int n_compared = 0;
    logic [2:0] opc [8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3, 3'h2};
    // entry masks: cam, attr, pa, hash, tag, data, branch target, history
    logic [31:0] lo_m [8] = '{32'hFFFFFFFF, 32'h00000FFF, 32'h1FFFFFFF, 32'h000000FF,
        32'h007FFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
    logic [31:0] hi_m [8] = '{32'h0000001F, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0000003F, 32'h0FFFFFFF, 32'h0};

    l1_array_debug_access #(.IDX_W(4)) l1_array_debug_access_inst (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_crm_in(req_crm_in), .req_opc2_in(req_opc2_in),
        .req_data_in(req_data_in), .mode_secure_in(mode_secure_in),
        .mode_priv_in(mode_priv_in), .resp_valid_out(resp_valid_out),
        .resp_undef_out(resp_undef_out), .resp_data_out(resp_data_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // one request, answer sampled at the falling edge after the taking edge
    task automatic op(input logic wr, input logic [3:0] crm, input logic [2:0] opc2,
                      input logic [31:0] data, input logic undef, output logic [31:0] rdata);
        @(negedge core_clk_in);
        req_valid_in = 1'b1;
        req_write_in = wr;
        req_crm_in = crm;
        req_opc2_in = opc2;
        req_data_in = data;
        @(negedge core_clk_in);
        req_valid_in = 1'b0;
        check("resp_valid", {31'h0, resp_valid_out}, 32'h1);
        check("resp_undef", {31'h0, resp_undef_out}, {31'h0, undef});
        rdata = resp_data_out;
    endtask : op

    task automatic stw(input int s, input int hi, input logic [31:0] d, input logic undef);
        logic [31:0] r;
        op(1'b1, 4'(s), 3'(hi), d, undef, r);
        check("staging write answer", r, 32'h0);
    endtask : stw

    task automatic str(input int s, input int hi, input logic [31:0] exp);
        logic [31:0] r;
        op(1'b0, 4'(s), 3'(hi), 32'h0, 1'b0, r);
        check("staging read", r, exp);
    endtask : str

    task automatic arr(input logic [3:0] crm, input logic [2:0] opc2, input int idx);
        logic [31:0] r;
        op(1'b1, crm, opc2, 32'(idx), 1'b0, r);
    endtask : arr

    function automatic logic [31:0] pat(input int k, input int s);
        return (s == 1 ? 32'h3C5A_69F0 : 32'hC3A5_960F) ^ 32'(k * 32'h0101_0101);
    endfunction : pat

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n_in = 1'b0;
        req_valid_in = 1'b0;
        req_write_in = 1'b0;
        req_crm_in = 4'h0;
        req_opc2_in = 3'h0;
        req_data_in = 32'h0;
        mode_secure_in = 1'b1;
        mode_priv_in = 1'b1;
        repeat (4) @(posedge core_clk_in);
        @(negedge core_clk_in);
        arst_n_in = 1'b1;
        @(negedge core_clk_in);
        for (int i = 0; i < 4; i++) str(i / 2, i % 2, `STAGE_RESET);
        $display("test reset values done");
        // staging registers keep all bits, each pair separate
        for (int i = 0; i < 4; i++) stw(i / 2, i % 2, 32'hF00D_0000 + 32'(i), 1'b0);
        for (int i = 0; i < 4; i++) str(i / 2, i % 2, 32'hF00D_0000 + 32'(i));
        $display("test staging access done");
        // every array kind, both sides where allowed; sides hold distinct entries
        for (int k = 0; k < 8; k++) begin
            for (int s = 0; s < 2; s++) if (k < 6 || s == 1) begin
                stw(s, 0, pat(k, s), 1'b0);
                stw(s, 1, ~pat(k, s), 1'b0);
                arr(k < 6 ? 4'(s) : `SEL_BRANCH_WR, opc[k], k + s);
            end
            for (int s = 0; s < 2; s++) if (k < 6 || s == 1) begin
                stw(s, 0, 32'h1234_5678, 1'b0);
                stw(s, 1, 32'h9ABC_DEF0, 1'b0);
                arr(k < 6 ? 4'(2 + s) : `SEL_BRANCH_RD, opc[k], k + s);
                str(s, 0, pat(k, s) & lo_m[k]);
                str(s, 1, hi_m[k] != 0 ? ~pat(k, s) & hi_m[k] : 32'h9ABC_DEF0);
            end
        end
        $display("test array round trips done");
        // refused modes change neither staging nor arrays
        stw(0, 0, 32'h0F0F_0F0F, 1'b0);
        for (int m = 0; m < 3; m++) begin
            mode_secure_in = (m == 1);
            mode_priv_in = (m == 0);
            stw(0, 0, 32'hFFFF_FFFF, 1'b1);
            op(1'b0, 4'h0, 3'h0, 32'h0, 1'b1, rd);
            check("refused staging read data", rd, 32'h0);
            op(1'b1, `SEL_DATA_WR, `OP2_CAM, 32'h0, 1'b1, rd);
            op(1'b1, `SEL_DATA_RD, `OP2_ATTR, 32'h1, 1'b1, rd);
            mode_secure_in = 1'b1;
            mode_priv_in = 1'b1;
            str(0, 0, 32'h0F0F_0F0F);
        end
        arr(`SEL_DATA_RD, `OP2_CAM, 0);
        str(0, 0, pat(0, 0));
        op(1'b0, `SEL_DATA_RD, `OP2_CAM, 32'h0, 1'b1, rd);
        check("read form of array op", rd, 32'h0);
        op(1'b1, 4'h4, 3'h2, 32'h0, 1'b1, rd);
        op(1'b1, 4'h2, 3'h0, 32'h0, 1'b1, rd);
        str(0, 0, pat(0, 0));
        $display("test refusals done");
        wrap_up();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk_in);
        num_errors++;
        wrap_up();
    end
endmodule : l1_array_debug_access_bench
